// [design/epmc_pkg.sv]
// shared constants and types for the eprom mode controller
package epmc_pkg;
   localparam int CLK_MHZ = 40;
   // read access delays in ns
   localparam int ADDRESS_ACCESS_DELAY_NS = 150;
   localparam int SELECT_TO_OUTPUT_DELAY_NS = 150;
   localparam int GATE_TO_OUTPUT_DELAY_NS = 50;
   localparam int FLOAT_DELAY_NS = 60;
   // programming timing in us
   localparam int SETUP_US = 1;
   localparam int DATA_HOLD_US = 1;
   localparam int PULSE_US = 100;
   localparam int SUPPLY_SETTLE_US = 1;
   // least times round up, pulse width uses typical figure
   localparam int ACCESS_CYC = (ADDRESS_ACCESS_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int GATE_CYC = (GATE_TO_OUTPUT_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int FLOAT_CYC = (FLOAT_DELAY_NS * CLK_MHZ + 999) / 1000;
   localparam int SETUP_CYC = SETUP_US * CLK_MHZ;
   localparam int HOLD_CYC = DATA_HOLD_US * CLK_MHZ;
   localparam int SETTLE_CYC = SUPPLY_SETTLE_US * CLK_MHZ;
   localparam int PULSE_CYC = PULSE_US * CLK_MHZ;
   localparam int CNT_W = 16;
   localparam int ADDR_W = 19;
   localparam int DATA_W = 8;

   typedef enum logic [3:0] {
      EPMC_IDLE = 4'h0,
      EPMC_RD_SEL = 4'h1,
      EPMC_RD_GATE = 4'h2,
      EPMC_RD_FLOAT = 4'h3,
      EPMC_PW_CORE = 4'h4,
      EPMC_PW_PROG = 4'h5,
      EPMC_PG_SETUP = 4'h6,
      EPMC_PG_PULSE = 4'h7,
      EPMC_PG_HOLD = 4'h8,
      EPMC_VF_GATE = 4'h9,
      EPMC_VF_FLOAT = 4'hA,
      EPMC_PD_PROG = 4'hB,
      EPMC_PD_CORE = 4'hC
   } epmc_state_t;

   typedef enum logic [1:0] {
      EPMC_CMD_READ = 2'h0,
      EPMC_CMD_PROGRAM = 2'h1,
      EPMC_CMD_VERIFY = 2'h2
   } epmc_cmd_t;
endpackage

// [design/epmc_timer_if.sv]
// carrier between the controller and its delay timer
`timescale 1ns/1ps
interface epmc_timer_if;
   logic load;
   logic [15:0] count;
   logic done;
   modport ctrl (output load, output count, input done);
   modport timer (input load, input count, output done);
endinterface

// [design/epmc_timer.sv]
// down counter that times pin sequencing delays
`timescale 1ns/1ps
module epmc_timer
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // controller side
   epmc_timer_if.timer tmr
);
   import epmc_pkg::*;

   typedef struct packed {
      logic [CNT_W-1:0] remain;
      logic done;
   } epmc_tmr_t;

   epmc_tmr_t state_reg;
   epmc_tmr_t state_next;

   always_comb
   begin
      state_next = state_reg;
      state_next.done = 1'b0;
      if (tmr.load)
      begin
         state_next.remain = tmr.count;
      end
      else if (state_reg.remain != '0)
      begin
         state_next.remain = state_reg.remain - 16'h0001;
         state_next.done = (state_reg.remain == 16'h0001);
      end
   end

   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         state_reg <= '0;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   assign tmr.done = state_reg.done;
endmodule // epmc_timer

// [design/epmc_ctrl.sv]
// host controller that sequences eprom pins and supplies for read and programming
// Function
// - select acts as power and device choice, the output gate alone gates data out.
// - the programming supply is high in the programming group and normal otherwise.
// - the core supply is raised in the programming group and normal otherwise.
// - the core supply comes up no later and goes down no earlier than the programming supply.
// - the program strobe is high before or when the programming supply rises.
// - in arrays select is the decoded choice and the gate follows the read strobe.
// - programming needs the high supply and the gate high, then a low pulse on select.
`timescale 1ns/1ps
module epmc_ctrl
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // command port
   input wire logic cmd_valid_i,
   input wire epmc_pkg::epmc_cmd_t cmd_i,
   input wire logic [epmc_pkg::ADDR_W-1:0] cmd_addr_i,
   input wire logic [epmc_pkg::DATA_W-1:0] cmd_data_i,
   output logic cmd_ready_o,
   output logic rsp_valid_o,
   output logic [epmc_pkg::DATA_W-1:0] rsp_data_o,
   // memory pins
   output logic [epmc_pkg::ADDR_W-1:0] mem_addr_o,
   output logic select_and_program_strobe_n_o,
   output logic gate_n_o,
   input wire logic [epmc_pkg::DATA_W-1:0] mem_data_i,
   output logic [epmc_pkg::DATA_W-1:0] mem_data_o,
   output logic mem_data_oe_o,
   // supply switches, high selects the programming level
   output logic prog_supply_high_o,
   output logic core_supply_high_o
);
   import epmc_pkg::*;

   typedef struct packed {
      epmc_state_t st;
      logic ready;
      logic rvalid;
      logic [DATA_W-1:0] rdata;
      logic [ADDR_W-1:0] addr;
      logic sel_n;
      logic gate_n;
      logic [DATA_W-1:0] wdata;
      logic wdrive;
      logic vpp_hi;
      logic vcc_hi;
      logic verify;
   } epmc_ctl_t;

   epmc_ctl_t state_reg;
   epmc_ctl_t state_next;
   logic [DATA_W-1:0] din_meta_reg;
   logic [DATA_W-1:0] din_sync_reg;

   epmc_timer_if tmr_bus();

   epmc_timer u_timer
   (
      .clock_i(clock_i),
      .reset_i(reset_i),
      .tmr(tmr_bus)
   );

   // ---------------------------------------------------------------
   // data pin synchroniser
   // ---------------------------------------------------------------
   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         din_meta_reg <= '0;
         din_sync_reg <= '0;
      end
      else
      begin
         din_meta_reg <= mem_data_i;
         din_sync_reg <= din_meta_reg;
      end
   end

   // ---------------------------------------------------------------
   // sequencer
   // ---------------------------------------------------------------
   logic [CNT_W-1:0] ld_count;
   logic ld;

   always_comb
   begin
      state_next = state_reg;
      state_next.rvalid = 1'b0;
      ld = 1'b0;
      ld_count = '0;
      case (state_reg.st)
         EPMC_IDLE:
         begin
            // standby: select and gate high, data floats
            state_next.sel_n = 1'b1;
            state_next.gate_n = 1'b1;
            state_next.ready = 1'b1;
            if (state_reg.ready && cmd_valid_i)
            begin
               state_next.ready = 1'b0;
               state_next.addr = cmd_addr_i;
               state_next.wdata = cmd_data_i;
               state_next.verify = (cmd_i == EPMC_CMD_VERIFY);
               if (cmd_i == EPMC_CMD_READ)
               begin
                  // address and select move together; access waits are equal
                  state_next.sel_n = 1'b0;
                  state_next.st = EPMC_RD_SEL;
                  ld = 1'b1;
                  ld_count = CNT_W'(ACCESS_CYC - GATE_CYC);
               end
               else
               begin
                  // strobe already high before any supply rises
                  state_next.sel_n = 1'b1;
                  state_next.vcc_hi = 1'b1;
                  state_next.st = EPMC_PW_CORE;
                  ld = 1'b1;
                  ld_count = CNT_W'(SETTLE_CYC);
               end
            end
         end
         EPMC_RD_SEL:
         begin
            if (tmr_bus.done)
            begin
               // gate falls one cycle more than access minus gate delay after select, which keeps access time
               state_next.gate_n = 1'b0;
               state_next.st = EPMC_RD_GATE;
               ld = 1'b1;
               ld_count = CNT_W'(GATE_CYC + 2);
            end
         end
         EPMC_RD_GATE, EPMC_VF_GATE:
         begin
            if (tmr_bus.done)
            begin
               // extra two cycles cover the synchroniser
               state_next.rdata = din_sync_reg;
               state_next.rvalid = 1'b1;
               state_next.gate_n = 1'b1;
               state_next.st = (state_reg.st == EPMC_RD_GATE) ? EPMC_RD_FLOAT : EPMC_VF_FLOAT;
               ld = 1'b1;
               ld_count = CNT_W'(FLOAT_CYC);
            end
         end
         EPMC_RD_FLOAT:
         begin
            if (tmr_bus.done)
            begin
               state_next.sel_n = 1'b1;
               state_next.st = EPMC_IDLE;
            end
         end
         EPMC_PW_CORE:
         begin
            if (tmr_bus.done)
            begin
               state_next.vpp_hi = 1'b1;
               state_next.st = EPMC_PW_PROG;
               ld = 1'b1;
               ld_count = CNT_W'(SETUP_CYC);
            end
         end
         EPMC_PW_PROG:
         begin
            if (tmr_bus.done)
            begin
               if (state_reg.verify)
               begin
                  // verify: select and gate low together with high supply
                  state_next.sel_n = 1'b0;
                  state_next.gate_n = 1'b0;
                  state_next.st = EPMC_VF_GATE;
                  ld = 1'b1;
                  ld_count = CNT_W'(ACCESS_CYC + 2);
               end
               else
               begin
                  // gate stays high and data driven before the pulse
                  state_next.wdrive = 1'b1;
                  state_next.st = EPMC_PG_SETUP;
                  ld = 1'b1;
                  ld_count = CNT_W'(SETUP_CYC);
               end
            end
         end
         EPMC_PG_SETUP:
         begin
            if (tmr_bus.done)
            begin
               state_next.sel_n = 1'b0;
               state_next.st = EPMC_PG_PULSE;
               ld = 1'b1;
               // timer ends one cycle after its count, so load one less for an exact pulse
               ld_count = CNT_W'(PULSE_CYC - 1);
            end
         end
         EPMC_PG_PULSE:
         begin
            if (tmr_bus.done)
            begin
               // back to inhibit; select high blocks further writes
               state_next.sel_n = 1'b1;
               state_next.st = EPMC_PG_HOLD;
               ld = 1'b1;
               ld_count = CNT_W'(HOLD_CYC);
            end
         end
         EPMC_PG_HOLD:
         begin
            if (tmr_bus.done)
            begin
               state_next.wdrive = 1'b0;
               state_next.rvalid = 1'b1;
               state_next.rdata = state_reg.wdata;
               state_next.vpp_hi = 1'b0;
               state_next.st = EPMC_PD_PROG;
               ld = 1'b1;
               ld_count = CNT_W'(SETTLE_CYC);
            end
         end
         EPMC_VF_FLOAT:
         begin
            if (tmr_bus.done)
            begin
               state_next.sel_n = 1'b1;
               state_next.vpp_hi = 1'b0;
               state_next.st = EPMC_PD_PROG;
               ld = 1'b1;
               ld_count = CNT_W'(SETTLE_CYC);
            end
         end
         EPMC_PD_PROG:
         begin
            if (tmr_bus.done)
            begin
               state_next.vcc_hi = 1'b0;
               state_next.st = EPMC_PD_CORE;
               ld = 1'b1;
               ld_count = CNT_W'(SETTLE_CYC);
            end
         end
         EPMC_PD_CORE:
         begin
            if (tmr_bus.done)
            begin
               state_next.st = EPMC_IDLE;
            end
         end
         default:
         begin
            state_next.st = EPMC_IDLE;
         end
      endcase
   end

   assign tmr_bus.load = ld;
   assign tmr_bus.count = ld_count;

   always_ff @(posedge clock_i)
   begin
      if (reset_i)
      begin
         state_reg <= '0;
         state_reg.st <= EPMC_IDLE;
         state_reg.sel_n <= 1'b1;
         state_reg.gate_n <= 1'b1;
      end
      else
      begin
         state_reg <= state_next;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   assign cmd_ready_o = state_reg.ready;
   assign rsp_valid_o = state_reg.rvalid;
   assign rsp_data_o = state_reg.rdata;
   assign mem_addr_o = state_reg.addr;
   assign select_and_program_strobe_n_o = state_reg.sel_n;
   assign gate_n_o = state_reg.gate_n;
   assign mem_data_o = state_reg.wdata;
   assign mem_data_oe_o = state_reg.wdrive;
   assign prog_supply_high_o = state_reg.vpp_hi;
   assign core_supply_high_o = state_reg.vcc_hi;
endmodule // epmc_ctrl

// [test/epmc_ctrl_checker.sv]
// port assertions for the eprom mode controller
`timescale 1ns/1ps
module epmc_ctrl_checker
import epmc_pkg::*;
(
   // clock and reset
   input wire logic clock_i,
   input wire logic reset_i,
   // observed outputs
   input wire logic cmd_ready_o,
   input wire logic select_and_program_strobe_n_o,
   input wire logic gate_n_o,
   input wire logic mem_data_oe_o,
   input wire logic prog_supply_high_o,
   input wire logic core_supply_high_o
);
   import epmc_pkg::*;
   logic [15:0] low_cnt_reg;
   // ---
   // pulse width counter
   // ---
   always_ff @(posedge clock_i)
   begin
      if (reset_i || select_and_program_strobe_n_o)
         low_cnt_reg <= 16'h0000;
      else
         low_cnt_reg <= low_cnt_reg + 16'h0001;
   end
   // ---
   // assertions
   // ---
   supply_order_a: assert property (@(posedge clock_i) disable iff (reset_i)
      prog_supply_high_o |-> core_supply_high_o) else $error("prog supply without core");
   strobe_first_a: assert property (@(posedge clock_i) disable iff (reset_i)
      $rose(prog_supply_high_o) |-> select_and_program_strobe_n_o && $past(core_supply_high_o))
      else $error("strobe low at prog supply rise");
   core_down_a: assert property (@(posedge clock_i) disable iff (reset_i)
      $fell(core_supply_high_o) |-> !prog_supply_high_o && $past(!prog_supply_high_o))
      else $error("core dropped before prog supply");
   program_mode_a: assert property (@(posedge clock_i) disable iff (reset_i)
      mem_data_oe_o |-> gate_n_o && prog_supply_high_o && core_supply_high_o)
      else $error("data driven outside program mode");
   pulse_width_a: assert property (@(posedge clock_i) disable iff (reset_i)
      $rose(select_and_program_strobe_n_o) && mem_data_oe_o |-> low_cnt_reg == PULSE_CYC)
      else $error("program pulse width wrong");
   read_gate_a: assert property (@(posedge clock_i) disable iff (reset_i)
      $fell(gate_n_o) && !prog_supply_high_o |->
      !select_and_program_strobe_n_o && $past(!select_and_program_strobe_n_o, 4))
      else $error("gate opened too early");
   verify_supply_a: assert property (@(posedge clock_i) disable iff (reset_i)
      !gate_n_o && prog_supply_high_o |-> core_supply_high_o && !mem_data_oe_o)
      else $error("verify supplies wrong");
   idle_pins_a: assert property (@(posedge clock_i) disable iff (reset_i)
      cmd_ready_o |-> select_and_program_strobe_n_o && gate_n_o && !mem_data_oe_o
      && !prog_supply_high_o && !core_supply_high_o) else $error("idle pins not standby");
endmodule // epmc_ctrl_checker
bind epmc_ctrl epmc_ctrl_checker epmc_ctrl_checker_i (.clock_i(clock_i), .reset_i(reset_i),
   .cmd_ready_o(cmd_ready_o), .select_and_program_strobe_n_o(select_and_program_strobe_n_o),
   .gate_n_o(gate_n_o), .mem_data_oe_o(mem_data_oe_o),
   .prog_supply_high_o(prog_supply_high_o), .core_supply_high_o(core_supply_high_o));

// [test/epmc_eprom_model.sv]
// behavioural eprom facing the controller
`timescale 1ns/1ps
module epmc_eprom_model
(
   // memory pins
   input wire logic [18:0] addr_i,
   input wire logic select_n_i,
   input wire logic gate_n_i,
   input wire logic [7:0] data_i,
   input wire logic data_oe_i,
   input wire logic prog_i,
   input wire logic core_i,
   output logic [7:0] data_o
);
   // only 16 cells, indexed by the low address bits
   logic [7:0] mem [0:15];
   logic [7:0] last;
   logic sel_d;
   logic gate_d;
   logic drive;
   initial
   begin
      for (int i = 0; i < 16; i++)
         mem[i] = 8'hC0 | i[7:0];
      last = 8'h00;
   end
   assign #150 sel_d = ~select_n_i;
   assign #50 gate_d = ~gate_n_i;
   assign drive = sel_d & gate_d & ~select_n_i & ~gate_n_i & ~data_oe_i;
   always @(drive or addr_i)
      if (drive)
         last = mem[addr_i[3:0]];
   // released pins show the inverse so stale data never passes
   assign data_o = drive ? last : ~last;
   // a byte is written only by a low pulse with gate high and supplies up
   always @(posedge select_n_i)
      if (prog_i && core_i && gate_n_i && data_oe_i)
         mem[addr_i[3:0]] = mem[addr_i[3:0]] & data_i;
endmodule // epmc_eprom_model

// [test/tb_epmc_ctrl.sv]
// self-checking bench for the eprom mode controller
`timescale 1ns/1ps
module tb_epmc_ctrl;
   import epmc_pkg::*;
   logic clock_i = 1'b0;
   logic reset_i = 1'b1;
   logic cmd_valid_i = 1'b0;
   epmc_cmd_t cmd_i = EPMC_CMD_READ;
   logic [ADDR_W-1:0] cmd_addr_i = 19'h00000;
   logic [DATA_W-1:0] cmd_data_i = 8'h00;
   logic cmd_ready_o, rsp_valid_o, sel_n, gate_n, oe, prog, core;
   logic [DATA_W-1:0] rsp_data_o, mem_rd, mem_wr;
   logic [ADDR_W-1:0] mem_addr;
   int err_count = 0;
   int total_checks = 0;
   int cyc = 0;
   always #12.5 clock_i = ~clock_i;
   epmc_ctrl epmc_ctrl_i (.clock_i(clock_i), .reset_i(reset_i), .cmd_valid_i(cmd_valid_i),
      .cmd_i(cmd_i), .cmd_addr_i(cmd_addr_i), .cmd_data_i(cmd_data_i),
      .cmd_ready_o(cmd_ready_o), .rsp_valid_o(rsp_valid_o), .rsp_data_o(rsp_data_o),
      .mem_addr_o(mem_addr), .select_and_program_strobe_n_o(sel_n), .gate_n_o(gate_n),
      .mem_data_i(mem_rd), .mem_data_o(mem_wr), .mem_data_oe_o(oe),
      .prog_supply_high_o(prog), .core_supply_high_o(core));
   epmc_eprom_model epmc_eprom_model_i (.addr_i(mem_addr), .select_n_i(sel_n), .gate_n_i(gate_n),
      .data_i(mem_wr), .data_oe_i(oe), .prog_i(prog), .core_i(core), .data_o(mem_rd));
   // ---
   // shared tasks
   // ---
   task stop_test;
      $display("errors %0d checks %0d", err_count, total_checks);
      if (err_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task chk(input logic [7:0] got, input logic [7:0] exp);
      total_checks++;
      if (got !== exp)
      begin
         err_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // holds the request until an edge with ready high takes it
   task run_cmd(input epmc_cmd_t c, input logic [18:0] a, input logic [7:0] d,
      input logic [7:0] exp);
      int n;
      @(negedge clock_i);
      cmd_valid_i = 1'b1;
      cmd_i = c;
      cmd_addr_i = a;
      cmd_data_i = d;
      while (cmd_ready_o !== 1'b1)
         @(negedge clock_i);
      @(negedge clock_i);
      cmd_valid_i = 1'b0;
      n = 0;
      while (rsp_valid_o !== 1'b1 && n < 6000)
      begin
         @(negedge clock_i);
         n++;
      end
      chk({7'h00, rsp_valid_o}, 8'h01);
      chk(rsp_data_o, exp);
      // response is a single cycle pulse
      @(negedge clock_i);
      chk({7'h00, rsp_valid_o}, 8'h00);
   endtask
   // ---
   // scenarios
   // ---
   task t_reset;
      repeat (3) @(negedge clock_i);
      chk({4'h0, cmd_ready_o, sel_n, gate_n, oe}, 8'h06);
      chk({6'h00, prog, core}, 8'h00);
      reset_i = 1'b0;
      @(negedge clock_i);
      chk({7'h00, cmd_ready_o}, 8'h01);
   endtask
   task t_read_pair;
      run_cmd(EPMC_CMD_READ, 19'h00005, 8'h00, 8'hC5);
      run_cmd(EPMC_CMD_READ, 19'h7FFFF, 8'h00, 8'hCF);
   endtask
   task t_program_verify;
      run_cmd(EPMC_CMD_PROGRAM, 19'h00003, 8'h5A, 8'h5A);
      chk({7'h00, oe}, 8'h00);
      run_cmd(EPMC_CMD_VERIFY, 19'h00003, 8'h00, 8'h42);
      run_cmd(EPMC_CMD_READ, 19'h00003, 8'h00, 8'h42);
   endtask
   task t_refused;
      // a request raised and dropped while busy is lost, memory stays in standby
      run_cmd(EPMC_CMD_READ, 19'h00001, 8'h00, 8'hC1);
      cmd_valid_i = 1'b1;
      cmd_addr_i = 19'h00002;
      repeat (2) @(negedge clock_i);
      cmd_valid_i = 1'b0;
      repeat (8) @(negedge clock_i);
      chk({6'h00, cmd_ready_o, sel_n}, 8'h03);
      run_cmd(EPMC_CMD_READ, 19'h00002, 8'h00, 8'hC2);
   endtask
   always @(posedge clock_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         err_count++;
         stop_test();
      end
   end
   initial
   begin
      t_reset();
      t_read_pair();
      t_program_verify();
      t_refused();
      repeat (20) @(negedge clock_i);
      stop_test();
   end
endmodule // tb_epmc_ctrl
